// ==== hdl/config_data_bus_width_mux.sv ====
// Configuration data bus front end: pin use per mode, width detection, beat FIFO.
//
// Function
// - Configuration data pins are sampled on the rising i_clk_sys edge through two synchronising stages.
// - Pins unused by mode and width are ignored and left undriven.
// - Pins are inputs, driven only for SPI serial out on D00, flash address, flash register write or readback.
// - SPI starts at x1; D00 sends to flash, D01 receives.
// - Stream settings can switch SPI read width to x2, x4 or x8.
// - SPI x4 and x8 use D02 and D03 as flash bits 2 and 3.
// - SPI x8 uses D[07:04] for a second flash, bit for bit.
// - Parallel slave detects x8, x16 or x32 from a low-byte pattern.
// - Parallel flash detects x8 or x16 from a low-byte pattern only.
// - Parallel flash drives D[31:16] as address bits A[15:00].
// - Boundary-scan mode ignores all data pins and keeps them undriven.
`timescale 1ns/100ps

module beat_fifo #(
   parameter int unsigned WIDTH = 8,
   parameter int unsigned DEPTH = 8
) (
   // Clock and reset
   input  wire logic             i_clk_sys,
   input  wire logic             i_rst,
   // Fill side
   input  wire logic             i_in_valid,
   output logic                  o_in_ready,
   input  wire logic [WIDTH-1:0] i_in_data,
   // Drain side
   output logic                  o_out_valid,
   input  wire logic             i_out_ready,
   output logic [WIDTH-1:0]      o_out_data
);
   localparam int unsigned PW = $clog2(DEPTH);

   // Pointer wrap relies on a power-of-two depth, so other depths are refused.
   if (DEPTH < 2 || (1 << PW) != DEPTH)
   begin : g_bad_depth
      $error("beat_fifo depth must be a power of two of at least 2");
   end

   logic [WIDTH-1:0] mem [DEPTH];
   logic [PW:0]      wr_ptr;
   logic [PW:0]      rd_ptr;
   logic             push;
   logic             pop;

   assign o_in_ready  = (wr_ptr ^ rd_ptr) != {1'b1, {PW{1'b0}}};
   assign o_out_valid = wr_ptr != rd_ptr;
   assign push        = i_in_valid & o_in_ready;
   assign pop         = o_out_valid & i_out_ready;
   assign o_out_data  = mem[rd_ptr[PW-1:0]];

   always_ff @(posedge i_clk_sys)
   begin
      if (push)
         mem[wr_ptr[PW-1:0]] <= i_in_data;
   end

   always_ff @(posedge i_clk_sys or posedge i_rst)
   begin
      if (i_rst)
      begin
         wr_ptr <= '0;
         rd_ptr <= '0;
      end
      else
      begin
         if (push)
            wr_ptr <= wr_ptr + 1'b1;
         if (pop)
            rd_ptr <= rd_ptr + 1'b1;
      end
   end
endmodule : beat_fifo

module config_data_bus_width_mux #(
   parameter int unsigned DEPTH = cfg_bus_pkg::FIFO_DEPTH
) (
   // Clock and reset
   input  wire logic                                i_clk_sys,
   input  wire logic                                i_rst,
   // Mode and load control
   input  wire cfg_bus_pkg::mode_e                  i_mode,
   input  wire logic                                i_cfg_active,
   input  wire logic                                i_sample_en,
   output logic                                     o_sample_ready,
   // SPI width switch from stream settings
   input  wire logic                                i_spi_width_load,
   input  wire cfg_bus_pkg::width_e                 i_spi_width_sel,
   input  wire logic                                i_spi_serial_out_bit0,
   input  wire logic                                i_spi_cmd_phase,
   // Parallel flash address and register write
   input  wire logic [cfg_bus_pkg::ADDR_W-1:0]      i_flash_addr,
   input  wire logic                                i_rcr_write,
   input  wire logic [cfg_bus_pkg::ADDR_W-1:0]      i_rcr_data,
   // Parallel slave readback
   input  wire logic                                i_readback,
   input  wire logic [cfg_bus_pkg::BUS_W-1:0]       i_readback_data,
   // Data bus pins
   input  wire logic [cfg_bus_pkg::BUS_W-1:0]       i_data_pin,
   output logic [cfg_bus_pkg::BUS_W-1:0]            o_data_pin,
   output logic [cfg_bus_pkg::BUS_W-1:0]            o_data_pin_oe,
   // Status
   output cfg_bus_pkg::width_e                      o_width,
   output logic                                     o_width_locked,
   // Captured beats
   output logic                                     o_beat_valid,
   input  wire logic                                i_beat_ready,
   output cfg_bus_pkg::beat_s                       o_beat
);
   localparam int unsigned BW = cfg_bus_pkg::BUS_W;
   localparam int unsigned AL = cfg_bus_pkg::ADDR_LO;
   localparam int unsigned AW = cfg_bus_pkg::ADDR_W;

   // Mask of pins that carry data at a given width.
   function automatic logic [BW-1:0] lane_mask(input cfg_bus_pkg::width_e w);
      logic [BW-1:0] m;
      m = '0;
      unique case (w)
         cfg_bus_pkg::W_X1:  m = 32'h0000_0002;
         cfg_bus_pkg::W_X2:  m = 32'h0000_0003;
         cfg_bus_pkg::W_X4:  m = 32'h0000_000F;
         cfg_bus_pkg::W_X8:  m = 32'h0000_00FF;
         cfg_bus_pkg::W_X16: m = 32'h0000_FFFF;
         cfg_bus_pkg::W_X32: m = 32'hFFFF_FFFF;
         default:            m = '0;
      endcase
      return m;
   endfunction : lane_mask

   logic [BW-1:0]       pin_meta;
   logic [BW-1:0]       pin_sync;
   cfg_bus_pkg::width_e spi_w;
   cfg_bus_pkg::width_e par_w;
   cfg_bus_pkg::det_e   det;
   cfg_bus_pkg::width_e act_w;
   logic                scan_mode;
   logic                parallel;
   logic                take;
   logic                fifo_ready;
   cfg_bus_pkg::beat_s  beat_in;
   logic [7:0]          low_byte;
   logic [BW-1:0]       par_mask;

   // Pins come from outside the clock domain, so two stages before use.
   always_ff @(posedge i_clk_sys or posedge i_rst)
   begin
      if (i_rst)
      begin
         pin_meta <= '0;
         pin_sync <= '0;
      end
      else
      begin
         pin_meta <= i_data_pin;
         pin_sync <= pin_meta;
      end
   end

   assign low_byte  = pin_sync[7:0];
   assign scan_mode = i_mode == cfg_bus_pkg::MODE_JTAG;
   assign parallel  = i_mode == cfg_bus_pkg::MODE_PSLAVE ||
                      i_mode == cfg_bus_pkg::MODE_PFLASH;

   // SPI width falls back to x1 whenever no load is running.
   always_ff @(posedge i_clk_sys or posedge i_rst)
   begin
      if (i_rst)
         spi_w <= cfg_bus_pkg::SPI_RESET_W;
      else if (!i_cfg_active)
         spi_w <= cfg_bus_pkg::SPI_RESET_W;
      else if (i_spi_width_load && i_mode == cfg_bus_pkg::MODE_SPI)
      begin
         unique case (i_spi_width_sel)
            cfg_bus_pkg::W_X1,
            cfg_bus_pkg::W_X2,
            cfg_bus_pkg::W_X4,
            cfg_bus_pkg::W_X8: spi_w <= i_spi_width_sel;
            default:           spi_w <= spi_w;
         endcase
      end
   end

   // Width detection; the lock holds until the load ends or the mode leaves parallel.
   always_ff @(posedge i_clk_sys or posedge i_rst)
   begin
      if (i_rst)
      begin
         det   <= cfg_bus_pkg::DET_IDLE;
         par_w <= cfg_bus_pkg::PAR_RESET_W;
      end
      else if (!i_cfg_active || !parallel)
      begin
         det   <= cfg_bus_pkg::DET_IDLE;
         par_w <= cfg_bus_pkg::PAR_RESET_W;
      end
      else if (i_sample_en)
      begin
         unique case (det)
            cfg_bus_pkg::DET_IDLE:
               if (low_byte == cfg_bus_pkg::DET_SYNC_BYTE)
                  det <= cfg_bus_pkg::DET_SYNC;
            cfg_bus_pkg::DET_SYNC:
            begin
               det <= cfg_bus_pkg::DET_LOCK;
               if (low_byte == cfg_bus_pkg::DET_X16_BYTE)
                  par_w <= cfg_bus_pkg::W_X16;
               else if (low_byte == cfg_bus_pkg::DET_X32_BYTE &&
                        i_mode == cfg_bus_pkg::MODE_PSLAVE)
                  par_w <= cfg_bus_pkg::W_X32;
               else
                  par_w <= cfg_bus_pkg::W_X8;
            end
            cfg_bus_pkg::DET_LOCK:
               det <= cfg_bus_pkg::DET_LOCK;
            default:
               det <= cfg_bus_pkg::DET_IDLE;
         endcase
      end
   end

   always_comb
   begin
      act_w = cfg_bus_pkg::W_X1;
      unique case (i_mode)
         cfg_bus_pkg::MODE_SPI:    act_w = spi_w;
         cfg_bus_pkg::MODE_PSLAVE,
         cfg_bus_pkg::MODE_PFLASH: act_w = par_w;
         default:                  act_w = cfg_bus_pkg::W_X1;
      endcase
   end

   // Parallel beats are held back until the width is settled.
   assign take = i_cfg_active && i_sample_en && !scan_mode &&
                 (!parallel || det == cfg_bus_pkg::DET_LOCK);
   assign beat_in.data  = pin_sync & lane_mask(act_w);
   assign beat_in.width = act_w;
   assign par_mask      = lane_mask(par_w);
   assign o_sample_ready = fifo_ready;

   beat_fifo #(
      .WIDTH ($bits(cfg_bus_pkg::beat_s)),
      .DEPTH (DEPTH)
   ) u_fifo (
      .i_clk_sys   (i_clk_sys),
      .i_rst       (i_rst),
      .i_in_valid  (take),
      .o_in_ready  (fifo_ready),
      .i_in_data   (beat_in),
      .o_out_valid (o_beat_valid),
      .i_out_ready (i_beat_ready),
      .o_out_data  (o_beat)
   );

   // Pin drive: everything floats unless a mode owns a pin for output.
   always_ff @(posedge i_clk_sys or posedge i_rst)
   begin
      if (i_rst)
      begin
         o_data_pin    <= '0;
         o_data_pin_oe <= '0;
      end
      else
      begin
         o_data_pin    <= '0;
         o_data_pin_oe <= '0;
         if (i_cfg_active)
         begin
            unique case (i_mode)
               cfg_bus_pkg::MODE_SPI:
                  if (spi_w == cfg_bus_pkg::W_X1 || i_spi_cmd_phase)
                  begin
                     o_data_pin[cfg_bus_pkg::SPI_OUT_BIT]    <= i_spi_serial_out_bit0;
                     o_data_pin_oe[cfg_bus_pkg::SPI_OUT_BIT] <= 1'b1;
                  end
               cfg_bus_pkg::MODE_PFLASH:
               begin
                  o_data_pin[AL +: AW]    <= i_flash_addr;
                  o_data_pin_oe[AL +: AW] <= '1;
                  if (i_rcr_write)
                  begin
                     o_data_pin[AW-1:0]    <= i_rcr_data;
                     o_data_pin_oe[AW-1:0] <= par_mask[AW-1:0];
                  end
               end
               cfg_bus_pkg::MODE_PSLAVE:
                  if (i_readback && det == cfg_bus_pkg::DET_LOCK)
                  begin
                     o_data_pin    <= i_readback_data & par_mask;
                     o_data_pin_oe <= par_mask;
                  end
               cfg_bus_pkg::MODE_SERIAL,
               cfg_bus_pkg::MODE_JTAG:
                  o_data_pin_oe <= '0;
               default:
                  o_data_pin_oe <= '0;
            endcase
         end
      end
   end

   always_ff @(posedge i_clk_sys or posedge i_rst)
   begin
      if (i_rst)
      begin
         o_width        <= cfg_bus_pkg::W_X1;
         o_width_locked <= 1'b0;
      end
      else
      begin
         o_width        <= act_w;
         o_width_locked <= !parallel || det == cfg_bus_pkg::DET_LOCK;
      end
   end

endmodule : config_data_bus_width_mux

// ==== hdl/cfg_bus_pkg.sv ====
// Shared types and constants for the configuration data bus front end.
package cfg_bus_pkg;

   localparam int unsigned BUS_W  = 32;
   localparam int unsigned ADDR_W = 16;
   localparam int unsigned ADDR_LO = 16;
   localparam int unsigned FIFO_DEPTH = 8;

   // Pin positions of the SPI lanes.
   localparam int unsigned SPI_OUT_BIT = 0;
   localparam int unsigned SPI_IN_BIT  = 1;

   // Bus width detection pattern on the low byte (sync byte, then width byte).
   localparam logic [7:0] DET_SYNC_BYTE = 8'hBB;
   localparam logic [7:0] DET_X8_BYTE   = 8'h11;
   localparam logic [7:0] DET_X16_BYTE  = 8'h22;
   localparam logic [7:0] DET_X32_BYTE  = 8'h44;

   typedef enum logic [4:0] {
      MODE_SERIAL = 5'h01,
      MODE_SPI    = 5'h02,
      MODE_PSLAVE = 5'h04,
      MODE_PFLASH = 5'h08,
      MODE_JTAG   = 5'h10
   } mode_e;

   typedef enum logic [5:0] {
      W_X1  = 6'h01,
      W_X2  = 6'h02,
      W_X4  = 6'h04,
      W_X8  = 6'h08,
      W_X16 = 6'h10,
      W_X32 = 6'h20
   } width_e;

   typedef enum logic [2:0] {
      DET_IDLE = 3'h1,
      DET_SYNC = 3'h2,
      DET_LOCK = 3'h4
   } det_e;

   // One captured beat: pins already masked to the active width.
   typedef struct packed {
      logic [BUS_W-1:0] data;
      width_e           width;
   } beat_s;

   localparam width_e SPI_RESET_W = W_X1;
   localparam width_e PAR_RESET_W = W_X8;

endpackage : cfg_bus_pkg

// ==== sim/cfg_bus_checker.sv ====
// Concurrent checks on the pins and status of the configuration data bus front end.
`timescale 1ns/100ps
module cfg_bus_checker (
   // Clock and reset
   input wire logic                i_clk_sys,
   input wire logic                i_rst,
   // Control
   input wire cfg_bus_pkg::mode_e  i_mode,
   input wire logic                i_cfg_active,
   input wire logic                i_sample_en,
   input wire logic                i_spi_width_load,
   input wire cfg_bus_pkg::width_e i_spi_width_sel,
   input wire logic                i_spi_serial_out_bit0,
   input wire logic [15:0]         i_flash_addr,
   // Outputs watched
   input wire logic                o_sample_ready,
   input wire logic [31:0]         o_data_pin,
   input wire logic [31:0]         o_data_pin_oe,
   input wire cfg_bus_pkg::width_e o_width,
   input wire logic                o_width_locked,
   input wire logic                o_beat_valid
);
   logic was_up;
   // Registered pin drive lags its inputs, so checks wait one edge after reset.
   always_ff @(posedge i_clk_sys or posedge i_rst)
      if (i_rst)
         was_up <= 1'b0;
      else
         was_up <= 1'b1;
   default clocking @(posedge i_clk_sys); endclocking
   default disable iff (i_rst);
   sequence s_take;
      i_cfg_active && i_sample_en && o_sample_ready && o_width_locked
         && i_mode != cfg_bus_pkg::MODE_JTAG;
   endsequence
   sequence s_was(cfg_bus_pkg::mode_e m);
      was_up && $past(i_mode) == m;
   endsequence
   chk_beat_follows: assert property (s_take |=> o_beat_valid)
      else $error("no beat after a taken sample");
   chk_jtag_hiz: assert property (s_was(cfg_bus_pkg::MODE_JTAG) |-> o_data_pin_oe == '0)
      else $error("pin driven in boundary-scan mode");
   chk_jtag_no_beat: assert property (
      i_mode == cfg_bus_pkg::MODE_JTAG && !o_beat_valid |=> !o_beat_valid)
      else $error("beat captured in boundary-scan mode");
   chk_serial_hiz: assert property (s_was(cfg_bus_pkg::MODE_SERIAL) |-> o_data_pin_oe == '0)
      else $error("pin driven in serial mode");
   chk_spi_unused_hiz: assert property (
      s_was(cfg_bus_pkg::MODE_SPI) |-> o_data_pin_oe[31:8] == '0 && !o_data_pin_oe[1])
      else $error("unused or input pin driven in SPI mode");
   chk_spi_serial_out: assert property (s_was(cfg_bus_pkg::MODE_SPI) ##0
      ($past(i_cfg_active) && $past(o_width) == cfg_bus_pkg::W_X1
      && o_width == cfg_bus_pkg::W_X1)
      |-> o_data_pin_oe[0] && o_data_pin[0] == $past(i_spi_serial_out_bit0))
      else $error("serial out bit not on D00");
   chk_flash_addr: assert property (s_was(cfg_bus_pkg::MODE_PFLASH)
      ##0 $past(i_cfg_active)
      |-> o_data_pin_oe[31:16] == 16'hFFFF && o_data_pin[31:16] == $past(i_flash_addr))
      else $error("flash address not on upper pins");
   chk_spi_width_load: assert property (i_cfg_active && i_mode == cfg_bus_pkg::MODE_SPI
      && i_spi_width_load && i_spi_width_sel inside {cfg_bus_pkg::W_X2, cfg_bus_pkg::W_X4,
      cfg_bus_pkg::W_X8} |-> ##2 o_width == $past(i_spi_width_sel, 2))
      else $error("SPI width not loaded");
   chk_flash_width: assert property (s_was(cfg_bus_pkg::MODE_PFLASH) ##0 o_width_locked
      |-> o_width inside {cfg_bus_pkg::W_X8, cfg_bus_pkg::W_X16})
      else $error("illegal flash width");
   chk_lock_hold: assert property ((o_width_locked && i_cfg_active
      && i_mode inside {cfg_bus_pkg::MODE_PSLAVE, cfg_bus_pkg::MODE_PFLASH})[*2]
      |=> $stable(o_width))
      else $error("width moved after lock");
endmodule : cfg_bus_checker

bind config_data_bus_width_mux cfg_bus_checker u_chk (.i_clk_sys, .i_rst, .i_mode,
   .i_cfg_active, .i_sample_en, .i_spi_width_load, .i_spi_width_sel, .i_spi_serial_out_bit0,
   .i_flash_addr, .o_sample_ready, .o_data_pin, .o_data_pin_oe, .o_width, .o_width_locked,
   .o_beat_valid);

// ==== sim/flash_model.sv ====
// Far-side flash or controller: presents words on the lanes it owns.
`timescale 1ns/100ps
module flash_model (
   input  wire logic        i_clk_sys,
   input  wire logic [31:0] i_word,
   input  wire logic [31:0] i_mask,
   input  wire logic [31:0] i_dev_out,
   input  wire logic [31:0] i_dev_oe,
   output logic [31:0]      o_pins
);
   logic [31:0] junk = 32'hA5C3_0F96;
   // Lanes nobody drives toggle every cycle, except bits set in 32'h0000_5A5A which hold, so stale values cannot pass for data.
   always @(posedge i_clk_sys)
      junk <= ~junk ^ 32'h0000_5A5A;
   always_comb
      o_pins = (i_dev_oe & i_dev_out) | (~i_dev_oe & ((i_mask & i_word) | (~i_mask & junk)));
endmodule : flash_model

// ==== sim/config_data_bus_width_mux_tb_top.sv ====
// Self-checking bench for the configuration data bus front end.
`timescale 1ns/100ps
module config_data_bus_width_mux_tb_top;
   typedef struct {logic [4:0] m; logic [7:0] key; logic [5:0] w;} row_s;
   logic                i_clk_sys = 1'b0;
   logic                i_rst = 1'b1;
   cfg_bus_pkg::mode_e  mode = cfg_bus_pkg::MODE_SERIAL;
   cfg_bus_pkg::width_e wsel = cfg_bus_pkg::W_X1;
   cfg_bus_pkg::width_e o_width;
   cfg_bus_pkg::beat_s  o_beat;
   logic                act = 1'b0;
   logic                smp = 1'b0;
   logic                wld = 1'b0;
   logic                rcr = 1'b0;
   logic                rdy = 1'b1;
   logic                sob = 1'b0;
   logic                rbk = 1'b0;
   logic                cmdp = 1'b0;
   logic                o_sample_ready, o_width_locked, o_beat_valid;
   logic [31:0]         word = 32'h0;
   logic [31:0]         mask = 32'hFF;
   logic [31:0]         pins, o_data_pin, o_data_pin_oe;
   int                  fail_count = 0;
   int                  tests_run = 0;
   int                  cyc = 0;
   int                  n;
   // Mode code, detection byte, expected width code, as the package encodes them.
   row_s rows [9] = '{'{5'h01, 8'h00, 6'h01}, '{5'h02, 8'h00, 6'h02}, '{5'h02, 8'h00, 6'h04},
      '{5'h02, 8'h00, 6'h08}, '{5'h04, 8'h11, 6'h08}, '{5'h04, 8'h22, 6'h10},
      '{5'h04, 8'h44, 6'h20}, '{5'h08, 8'h44, 6'h08}, '{5'h08, 8'h22, 6'h10}};

   config_data_bus_width_mux dut (.i_clk_sys, .i_rst, .i_mode(mode), .i_cfg_active(act),
      .i_sample_en(smp), .o_sample_ready, .i_spi_width_load(wld), .i_spi_width_sel(wsel),
      .i_spi_serial_out_bit0(sob), .i_spi_cmd_phase(cmdp), .i_flash_addr(word[31:16]),
      .i_rcr_write(rcr), .i_rcr_data(word[15:0]), .i_readback(rbk), .i_readback_data(word),
      .i_data_pin(pins), .o_data_pin, .o_data_pin_oe, .o_width, .o_width_locked,
      .o_beat_valid, .i_beat_ready(rdy), .o_beat);
   flash_model far (.i_clk_sys, .i_word(word), .i_mask(mask), .i_dev_out(o_data_pin),
      .i_dev_oe(o_data_pin_oe), .o_pins(pins));

   always #12.5 i_clk_sys = ~i_clk_sys;

   // The serial bit moves just after each edge, so the design never races the bench.
   always @(posedge i_clk_sys) #1 sob = ~sob;

   task automatic wrap_up;
      $display("checks %0d mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : wrap_up

   always @(posedge i_clk_sys)
   begin
      cyc++;
      if (cyc == 3000)
      begin
         fail_count++;
         wrap_up();
      end
   end

   task automatic tick(input int k);
      repeat (k) @(posedge i_clk_sys);
      #1;
   endtask : tick

   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      tests_run++;
      if (got !== exp)
      begin
         fail_count++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask : check

   // Width codes equal their lane counts, except x1 which reads D01.
   function automatic logic [31:0] lanes(input logic [5:0] w);
      return (w == 6'h01) ? 32'h2 : 32'((33'h1 << w) - 33'h1);
   endfunction : lanes

   task automatic take(input logic [31:0] w);
      word = w;
      tick(3);
      smp = 1'b1;
      tick(1);
      smp = 1'b0;
   endtask : take

   task automatic start(input cfg_bus_pkg::mode_e m);
      act = 1'b0;
      mode = m;
      tick(2);
      act = 1'b1;
      tick(1);
   endtask : start

   task automatic hold_reset(input int k);
      i_rst = 1'b1;
      tick(k);
      check("oe", 32'h0, o_data_pin_oe);
      check("width", 32'(cfg_bus_pkg::W_X1), 32'(o_width));
      check("flags", 32'h0, {30'h0, o_width_locked, o_beat_valid});
      i_rst = 1'b0;
   endtask : hold_reset

   initial
   begin
      hold_reset(6);
      foreach (rows[i])
      begin
         start(cfg_bus_pkg::mode_e'(rows[i].m));
         mask = lanes(rows[i].w) | 32'hFF;
         wsel = cfg_bus_pkg::width_e'(rows[i].w);
         wld = (rows[i].m == 5'h02);
         tick(1);
         wld = 1'b0;
         if (rows[i].key != 8'h00)
         begin
            take(32'hBB);
            take({24'h0, rows[i].key});
         end
         take(32'h6C3A_95E7);
         check("width", 32'(rows[i].w), 32'(o_width));
         check("valid", 32'h1, 32'(o_beat_valid));
         check("beat", 32'h6C3A_95E7 & lanes(rows[i].w), o_beat.data);
         check("beat width", 32'(rows[i].w), 32'(o_beat.width));
         $display("row %0d done", i);
      end
      rcr = 1'b1;
      tick(1);
      check("rcr oe", 32'hFFFF, 32'(o_data_pin_oe[15:0]));
      check("rcr data", 32'h95E7, 32'(o_data_pin[15:0]));
      rcr = 1'b0;
      take(32'hBB);
      take(32'h44);
      check("held width", 32'(cfg_bus_pkg::W_X16), 32'(o_width));
      $display("flash write and lock hold done");
      start(cfg_bus_pkg::MODE_PSLAVE);
      take(32'h1234_5678);
      check("unlocked beat", 32'h0, 32'(o_beat_valid));
      check("unlocked", 32'h0, 32'(o_width_locked));
      rbk = 1'b1;
      tick(1);
      check("readback oe unlocked", 32'h0, o_data_pin_oe);
      take(32'hBB);
      take(32'h22);
      tick(1);
      check("locked", 32'h1, 32'(o_width_locked));
      check("readback oe", 32'h0000_FFFF, o_data_pin_oe);
      check("readback data", 32'h0000_0022, o_data_pin);
      rbk = 1'b0;
      start(cfg_bus_pkg::MODE_JTAG);
      take(32'h1234_5678);
      check("scan beat", 32'h0, 32'(o_beat_valid));
      check("scan oe", 32'h0, o_data_pin_oe);
      $display("refusals done");
      start(cfg_bus_pkg::MODE_SPI);
      rdy = 1'b0;
      repeat (cfg_bus_pkg::FIFO_DEPTH + 1) take(32'h2);
      check("ready when full", 32'h0, 32'(o_sample_ready));
      check("start width", 32'(cfg_bus_pkg::W_X1), 32'(o_width));
      rdy = 1'b1;
      n = 0;
      repeat (12)
      begin
         n += int'(o_beat_valid === 1'b1);
         tick(1);
      end
      check("drained", 32'(cfg_bus_pkg::FIFO_DEPTH), 32'(n));
      wsel = cfg_bus_pkg::W_X4;
      wld = 1'b1;
      tick(1);
      wld = 1'b0;
      tick(1);
      check("wide oe", 32'h0, o_data_pin_oe);
      cmdp = 1'b1;
      tick(1);
      check("command oe", 32'h1, o_data_pin_oe);
      cmdp = 1'b0;
      $display("buffer done");
      hold_reset(2);
      $display("reset done");
      wrap_up();
   end
endmodule : config_data_bus_width_mux_tb_top
